// ==== hdl/clke_top.sv ====
// clke_top: reports sixteen channel levels and drives four windowed knock outputs.
// assumes the host holds its settings as steady levels; pins enter through clke_sync2.
//
// How it works
// - level word bit n is channel n, one means high.
// - level bits of channels without running measurement are forced to zero.
// - level word updates every cycle from the sampled channel pins.
// - four knock outputs, each enabled by its own host bit.
// - per bank of eight channels a two-bit threshold source select.
// - per output polarity, zero means active low, one active high.
// - lower and upper window limits clamped to -720..+720 degrees.
// - all settings are taken live, no stop or restart needed.
// - crank angle counts 1440 angle ticks per 720 degrees.
`timescale 1ns/1ps
module clke_top
    import clke_pkg::*;
#(
    parameter int NUM_CH = clke_pkg::CLKE_NUM_CH,
    parameter int NUM_KNOCK = clke_pkg::CLKE_NUM_KNOCK
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [15:0] channel_pin_i,
    input wire logic [15:0] meas_active_i,
    input wire logic angle_tick_pin_i,
    input wire logic angle_sync_pin_i,
    input wire logic [3:0] knock_output_enable_i,
    input wire logic [3:0] knock_polarity_i,
    input wire logic signed [11:0] window_lower_i,
    input wire logic signed [11:0] window_upper_i,
    input wire logic [1:0] thr_sel_lo_i,
    input wire logic [1:0] thr_sel_hi_i,
    output logic [15:0] channel_level_word_o,
    output logic [3:0] knock_out_o,
    output logic [1:0] thr_src_lo_o,
    output logic [1:0] thr_src_hi_o,
    output logic [10:0] crank_angle_o
);
    import clke_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two flops per pin; a pin pulse shorter than one clock period may be missed
    localparam int SYNC_W = NUM_CH + 2;
    logic [SYNC_W-1:0] pins_sync;

    clke_sync2 #(
        .W(SYNC_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i({angle_sync_pin_i, angle_tick_pin_i, channel_pin_i}),
        .q_o(pins_sync)
    );

    // ------------------------------------------------------------
    // level word
    // ------------------------------------------------------------
    logic [15:0] level_r;
    logic [15:0] level_nxt;

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_level
            // inactive channels read zero so stale levels never look valid
            always_comb begin
                level_nxt[gc] = pins_sync[gc] && meas_active_i[gc];
                if (srst_i) begin
                    level_nxt[gc] = CLKE_LEVEL_RST[gc];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        level_r <= level_nxt;
    end

    // ------------------------------------------------------------
    // crank angle counter
    // ------------------------------------------------------------
    logic tick_d_r;
    logic tick_d_nxt;
    logic sync_d_r;
    logic sync_d_nxt;
    logic [10:0] angle_r;
    logic [10:0] angle_nxt;
    logic tick_rise;
    logic sync_rise;
    logic angle_last;

    always_comb begin
        tick_d_nxt = pins_sync[16];
        sync_d_nxt = pins_sync[17];
        // edges are taken from synchronised copies only, never from the raw pins
        tick_rise = pins_sync[16] && !tick_d_r;
        sync_rise = pins_sync[17] && !sync_d_r;
        angle_last = (angle_r == 11'(CLKE_ANGLE_TICKS - 1));
        angle_nxt = angle_r;
        // the sync edge wins over a tick in the same cycle so the zero point is exact
        if (sync_rise) begin
            angle_nxt = CLKE_ANGLE_RST;
        end else if (tick_rise) begin
            if (angle_last) begin
                angle_nxt = CLKE_ANGLE_RST;
            end else begin
                angle_nxt = angle_r + 11'h001;
            end
        end
        if (srst_i) begin
            tick_d_nxt = 1'b0;
            sync_d_nxt = 1'b0;
            angle_nxt = CLKE_ANGLE_RST;
        end
    end

    // limitation: forward rotation only; a missed tick is repaired at the next sync edge
    always_ff @(posedge ref_clk_i) begin
        tick_d_r <= tick_d_nxt;
        sync_d_r <= sync_d_nxt;
        angle_r <= angle_nxt;
    end

    // ------------------------------------------------------------
    // knock window
    // ------------------------------------------------------------
    logic signed [11:0] lo_clamp;
    logic signed [11:0] hi_clamp;
    logic signed [12:0] angle_s;
    logic in_window;
    logic signed [12:0] lo_ext;
    logic signed [12:0] hi_ext;
    logic signed [12:0] angle_prev;
    logic in_cur;
    logic in_prev;

    function automatic logic signed [11:0] clke_clamp(input logic signed [11:0] v);
        logic signed [11:0] r;
        r = v;
        if (v > CLKE_LIMIT_MAX) begin
            r = CLKE_LIMIT_MAX;
        end else if (v < CLKE_LIMIT_MIN) begin
            r = CLKE_LIMIT_MIN;
        end
        return r;
    endfunction : clke_clamp

    always_comb begin
        lo_clamp = clke_clamp(window_lower_i);
        hi_clamp = clke_clamp(window_upper_i);
        angle_s = signed'({2'b00, angle_r});
        lo_ext = 13'(lo_clamp);
        hi_ext = 13'(hi_clamp);
        // negative limits name the previous cycle, so also test angle minus 720 degrees
        angle_prev = angle_s - 13'(CLKE_ANGLE_TICKS);
        in_cur = (angle_s >= lo_ext) && (angle_s <= hi_ext);
        in_prev = (angle_prev >= lo_ext) && (angle_prev <= hi_ext);
        // both limits inclusive; a window with lower above upper stays closed
        in_window = in_cur || in_prev;
    end

    // ------------------------------------------------------------
    // knock outputs and threshold select
    // ------------------------------------------------------------
    logic [3:0] knock_r;
    logic [3:0] knock_nxt;
    logic [1:0] thr_lo_r;
    logic [1:0] thr_lo_nxt;
    logic [1:0] thr_hi_r;
    logic [1:0] thr_hi_nxt;

    logic [3:0] knock_active;

    genvar gk;
    generate
        for (gk = 0; gk < NUM_KNOCK; gk++) begin : g_knock
            // active level follows polarity; idle level is its inverse
            always_comb begin
                knock_active[gk] = knock_output_enable_i[gk] && in_window;
                knock_nxt[gk] = knock_active[gk]
                    ? knock_polarity_i[gk] : !knock_polarity_i[gk];
                // reset holds a constant; polarity is applied the first cycle after release
                if (srst_i) begin
                    knock_nxt[gk] = CLKE_KNOCK_RST[gk];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        knock_r <= knock_nxt;
    end

    // ------------------------------------------------------------
    // threshold source select
    // ------------------------------------------------------------
    always_comb begin
        thr_lo_nxt = thr_sel_lo_i;
        thr_hi_nxt = thr_sel_hi_i;
        if (srst_i) begin
            thr_lo_nxt = CLKE_THR_RST;
            thr_hi_nxt = CLKE_THR_RST;
        end
    end

    // codes are registered so the comparator reference never sees a combinational glitch
    always_ff @(posedge ref_clk_i) begin
        thr_lo_r <= thr_lo_nxt;
        thr_hi_r <= thr_hi_nxt;
    end

    assign channel_level_word_o = level_r;
    assign knock_out_o = knock_r;
    assign thr_src_lo_o = thr_lo_r;
    assign thr_src_hi_o = thr_hi_r;
    assign crank_angle_o = angle_r;
endmodule : clke_top

// ==== hdl/clke_pkg.sv ====
// clke_pkg: shared constants for the channel level and knock enable block.
// assumes a single 100 MHz clock domain and synchronous active-high reset.
package clke_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CLKE_NUM_CH = 16;
    localparam int CLKE_BANK_CH = 8;
    localparam int CLKE_NUM_KNOCK = 4;
    // angle clock: ticks per full 720 degree cycle, half degree each
    localparam int CLKE_ANGLE_TICKS = 1440;
    localparam int CLKE_ANGLE_W = 11;
    // signed half-degree limit width, covers -1440..+1440
    localparam int CLKE_LIMIT_W = 12;
    localparam logic signed [11:0] CLKE_LIMIT_MAX = 12'sh5A0;
    localparam logic signed [11:0] CLKE_LIMIT_MIN = -12'sh5A0;
    // ------------------------------------------------------------
    // threshold source codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLKE_THR_2V5,
        CLKE_THR_BATT_A,
        CLKE_THR_BATT_B,
        CLKE_THR_EXT
    } clke_thr_t;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CLKE_LEVEL_RST = 16'h0000;
    localparam logic [3:0] CLKE_KNOCK_RST = 4'h0;
    localparam logic [1:0] CLKE_THR_RST = 2'h0;
    localparam logic [10:0] CLKE_ANGLE_RST = 11'h000;
endpackage : clke_pkg

// ==== hdl/clke_sync2.sv ====
// clke_sync2: two flip-flop synchroniser for a vector of pin levels.
// assumes the inputs are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module clke_sync2 #(
    parameter int W = 16
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = d_i;
        sync_nxt = meta_r;
        if (srst_i) begin
            meta_nxt = '0;
            sync_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign q_o = sync_r;
endmodule : clke_sync2

// ==== testbench/clke_properties.sv ====
// clke_properties: port checks for clke_top.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module clke_properties #(
    parameter int NUM_CH = 16,
    parameter int NUM_KNOCK = 4
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [15:0] channel_pin_i,
    input wire logic [15:0] meas_active_i,
    input wire logic angle_tick_pin_i,
    input wire logic angle_sync_pin_i,
    input wire logic [3:0] knock_output_enable_i,
    input wire logic [3:0] knock_polarity_i,
    input wire logic signed [11:0] window_lower_i,
    input wire logic signed [11:0] window_upper_i,
    input wire logic [1:0] thr_sel_lo_i,
    input wire logic [1:0] thr_sel_hi_i,
    input wire logic [15:0] channel_level_word_o,
    input wire logic [3:0] knock_out_o,
    input wire logic [1:0] thr_src_lo_o,
    input wire logic [1:0] thr_src_hi_o,
    input wire logic [10:0] crank_angle_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    logic signed [12:0] ang;
    logic in_win;
    logic [42:0] cfg;
    // second term catches windows given in the previous cycle
    assign ang = signed'({2'h0, crank_angle_o});
    assign in_win = (window_lower_i <= ang && ang <= window_upper_i) ||
        (window_lower_i <= ang - 13'sh5A0 && ang - 13'sh5A0 <= window_upper_i);
    assign cfg = {window_lower_i, window_upper_i, knock_output_enable_i,
        knock_polarity_i, crank_angle_o};
    sequence s_steady;
        ($stable(channel_pin_i) && $stable(meas_active_i))[*5];
    endsequence
    property p_lvl;
        s_steady |-> channel_level_word_o == (channel_pin_i & meas_active_i);
    endproperty
    property p_thr_lo;
        !$past(srst_i) |-> thr_src_lo_o == $past(thr_sel_lo_i);
    endproperty
    property p_thr_hi;
        !$past(srst_i) |-> thr_src_hi_o == $past(thr_sel_hi_i);
    endproperty
    property p_k_idle;
        !$past(srst_i) |->
            ((knock_out_o ^ $past(knock_polarity_i)) | $past(knock_output_enable_i)) == 4'hF;
    endproperty
    property p_k_in;
        in_win && $stable(cfg) && !$past(srst_i) |->
            knock_out_o == (knock_polarity_i ^ ~knock_output_enable_i);
    endproperty
    property p_k_out;
        !in_win && $stable(cfg) && !$past(srst_i) |-> knock_out_o == ~knock_polarity_i;
    endproperty
    property p_ang_step;
        $changed(crank_angle_o) |->
            crank_angle_o == 11'h000 || crank_angle_o == $past(crank_angle_o) + 11'h001;
    endproperty
    property p_ang_rng;
        crank_angle_o < 11'h5A0;
    endproperty
    a_lvl: assert property (p_lvl) else $error("level word");
    a_thr_lo: assert property (p_thr_lo) else $error("thr lo");
    a_thr_hi: assert property (p_thr_hi) else $error("thr hi");
    a_k_idle: assert property (p_k_idle) else $error("knock idle");
    a_k_in: assert property (p_k_in) else $error("knock in");
    a_k_out: assert property (p_k_out) else $error("knock out");
    a_ang_step: assert property (p_ang_step) else $error("angle step");
    a_ang_rng: assert property (p_ang_rng) else $error("angle range");
endmodule : clke_properties

// ==== testbench/clke_host_model.sv ====
// clke_host_model: host that rewrites the knock enable group.
// assumes want_i changes just after clock edges.
`timescale 1ns/1ps
module clke_host_model (
    input wire logic ref_clk_i,
    input wire logic [3:0] want_i,
    output logic [3:0] knock_en_o
);
    initial knock_en_o = 4'h0;
    // writes land live, one cycle late, and only on a change
    always @(posedge ref_clk_i) begin
        if (want_i !== knock_en_o) begin
            knock_en_o <= want_i;
        end
    end
endmodule : clke_host_model

// ==== testbench/clke_top_bench.sv ====
// clke_top_bench: random and corner stimulus for clke_top.
// assumes the package, design, checker and host model are compiled first.
`timescale 1ns/1ps
module clke_top_bench;
    logic ref_clk_i, srst_i, angle_tick_pin_i, angle_sync_pin_i;
    logic [15:0] channel_pin_i, meas_active_i, channel_level_word_o, r;
    logic [3:0] knock_output_enable_i, knock_polarity_i, knock_out_o, want, kx;
    logic signed [11:0] window_lower_i, window_upper_i;
    logic [1:0] thr_sel_lo_i, thr_sel_hi_i, thr_src_lo_o, thr_src_hi_o;
    logic [10:0] crank_angle_o;
    int n_errors, check_count, lo, hi;
    int wl[4] = '{0, 3, -1440, -1440};
    int wh[4] = '{2, 1440, -1438, -1439};
    clke_top DUT (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .channel_pin_i(channel_pin_i),
        .meas_active_i(meas_active_i),
        .angle_tick_pin_i(angle_tick_pin_i),
        .angle_sync_pin_i(angle_sync_pin_i),
        .knock_output_enable_i(knock_output_enable_i),
        .knock_polarity_i(knock_polarity_i),
        .window_lower_i(window_lower_i),
        .window_upper_i(window_upper_i),
        .thr_sel_lo_i(thr_sel_lo_i),
        .thr_sel_hi_i(thr_sel_hi_i),
        .channel_level_word_o(channel_level_word_o),
        .knock_out_o(knock_out_o),
        .thr_src_lo_o(thr_src_lo_o),
        .thr_src_hi_o(thr_src_hi_o),
        .crank_angle_o(crank_angle_o)
    );
    clke_host_model u_host (
        .ref_clk_i(ref_clk_i),
        .want_i(want),
        .knock_en_o(knock_output_enable_i)
    );
    task automatic chk(input string nm, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc
    task automatic pulse(input bit s, input int n);
        repeat (n) begin
            if (s) angle_sync_pin_i <= 1'b1;
            else angle_tick_pin_i <= 1'b1;
            cyc(2);
            angle_sync_pin_i <= 1'b0;
            angle_tick_pin_i <= 1'b0;
            cyc(2);
        end
    endtask : pulse
    function automatic logic [3:0] kexp(input int a, l, h, input logic [3:0] en, pol);
        if ((l <= a && a <= h) || (l <= a - 1440 && a - 1440 <= h)) return pol ^ ~en;
        return ~pol;
    endfunction : kexp
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #900000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {srst_i, angle_tick_pin_i, angle_sync_pin_i} = 3'h4;
        {channel_pin_i, meas_active_i, want, knock_polarity_i} = 40'h0;
        {window_lower_i, window_upper_i, thr_sel_lo_i, thr_sel_hi_i} = 28'h0;
        void'($urandom(92));
        cyc(12);
        srst_i <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            thr_sel_lo_i <= c[1:0];
            thr_sel_hi_i <= 2'h3 - c[1:0];
            cyc(2);
            chk("thr_lo", 16'(c), 16'(thr_src_lo_o));
            chk("thr_hi", 16'(3 - c), 16'(thr_src_hi_o));
        end
        // first two passes: all channels high, then none measured
        for (int i = 0; i < 24; i++) begin
            r = (i < 2) ? 16'hFFFF : 16'($urandom);
            channel_pin_i <= r;
            meas_active_i <= (i == 1) ? 16'h0000 : ((i == 0) ? 16'hFFFF : 16'($urandom));
            cyc(5);
            chk("level", r & meas_active_i, channel_level_word_o);
        end
        pulse(1'b1, 1);
        pulse(1'b0, 5);
        cyc(6);
        chk("angle", 16'h0005, 16'(crank_angle_o));
        pulse(1'b0, 1437);
        cyc(6);
        chk("angle_wrap", 16'h0002, 16'(crank_angle_o));
        for (int k = 0; k < 12; k++) begin
            lo = (k < 4) ? wl[k] : int'($urandom_range(2880)) - 1440;
            hi = (k < 4) ? wh[k] : int'($urandom_range(2880)) - 1440;
            want <= 4'($urandom);
            knock_polarity_i <= 4'($urandom);
            window_lower_i <= 12'(lo);
            window_upper_i <= 12'(hi);
            cyc(4);
            kx = kexp(2, lo, hi, want, knock_polarity_i);
            chk("knock", 16'(kx), 16'(knock_out_o));
        end
        // mid-run reset: outputs fall to reset values, then resume from angle zero
        srst_i <= 1'b1;
        cyc(3);
        chk("rst_level", 16'h0000, channel_level_word_o);
        chk("rst_thr", 16'h0000, 16'({thr_src_hi_o, thr_src_lo_o}));
        chk("rst_knock", 16'h0000, 16'(knock_out_o));
        chk("rst_angle", 16'h0000, 16'(crank_angle_o));
        srst_i <= 1'b0;
        cyc(6);
        kx = kexp(0, lo, hi, want, knock_polarity_i);
        chk("knock_rst", 16'(kx), 16'(knock_out_o));
        chk("level_rst", r & meas_active_i, channel_level_word_o);
        tally_and_finish();
    end
endmodule : clke_top_bench
bind clke_top clke_properties #(
    .NUM_CH(NUM_CH),
    .NUM_KNOCK(NUM_KNOCK)
) u_props (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .channel_pin_i(channel_pin_i),
    .meas_active_i(meas_active_i),
    .angle_tick_pin_i(angle_tick_pin_i),
    .angle_sync_pin_i(angle_sync_pin_i),
    .knock_output_enable_i(knock_output_enable_i),
    .knock_polarity_i(knock_polarity_i),
    .window_lower_i(window_lower_i),
    .window_upper_i(window_upper_i),
    .thr_sel_lo_i(thr_sel_lo_i),
    .thr_sel_hi_i(thr_sel_hi_i),
    .channel_level_word_o(channel_level_word_o),
    .knock_out_o(knock_out_o),
    .thr_src_lo_o(thr_src_lo_o),
    .thr_src_hi_o(thr_src_hi_o),
    .crank_angle_o(crank_angle_o)
);
